// file: shared/crc_scan_pkg.sv
// Shared constants, register map and field layout of the CRC scanner block.
package crc_scan_pkg;

  // Register index width and data width of the register port.
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;

  // Register offsets on the register port.
  localparam logic [3:0] OFS_CRC_CTL   = 4'h0;
  localparam logic [3:0] OFS_SCAN_CTL  = 4'h1;
  localparam logic [3:0] OFS_ADDR_LO   = 4'h2;
  localparam logic [3:0] OFS_ADDR_HI   = 4'h3;
  localparam logic [3:0] OFS_END_LO    = 4'h4;
  localparam logic [3:0] OFS_END_HI    = 4'h5;
  localparam logic [3:0] OFS_DATA_LO   = 4'h6;
  localparam logic [3:0] OFS_DATA_HI   = 4'h7;
  localparam logic [3:0] OFS_ACC_LO    = 4'h8;
  localparam logic [3:0] OFS_ACC_HI    = 4'h9;

  // Field positions in crc_control_status_0.
  localparam int CTL_EN_BIT     = 7;
  localparam int CTL_START_BIT  = 6;
  localparam int CTL_BUSY_BIT   = 5;
  localparam int CTL_ACCUMULATOR_AUGMENT_MODE_BIT   = 4;
  localparam int CTL_SHIFT_DIRECTION_SELECT_BIT = 1;
  localparam int CTL_FULL_BIT   = 0;

  // Field positions in scan_control_reg.
  localparam int SCAN_GO_BIT    = 7;
  localparam int SCAN_FROZE_BIT = 6;
  localparam int SCAN_MODE_LSB  = 0;

  // Values after reset.
  localparam logic [7:0]  CRC_CTL_RESET  = 8'h00;
  localparam logic [1:0]  SCAN_MODE_RESET = 2'h0;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;

  // Scan mode encodings.
  localparam logic [1:0] MODE_CONCURRENT = 2'h0;
  localparam logic [1:0] MODE_BURST      = 2'h1;
  localparam logic [1:0] MODE_PEEK       = 2'h2;
  localparam logic [1:0] MODE_TRIGGERED  = 2'h3;

  // CRC engine sizes and default polynomial.
  localparam int          CRC_W        = 16;
  localparam logic [4:0]  WORD_BITS    = 5'h10;
  localparam logic [15:0] DEFAULT_POLY = 16'h1021;

endpackage

// file: shared/crc_if.sv
// Carrier between the scanner control, its feed stage and the CRC engine.
`timescale 1ns/1ns
interface crc_if;
  logic [15:0] word;
  logic        valid;
  logic        ready;
  logic        en;
  logic        start;
  logic        accumulator_augment_mode;
  logic        shift_direction_select;
  logic        busy;
  logic        full;
  logic [15:0] acc;

  modport feeder
  (
    output word,
    output valid,
    input  ready
  );
  modport engine
  (
    input  word,
    input  valid,
    input  en,
    input  start,
    input  accumulator_augment_mode,
    input  shift_direction_select,
    output ready,
    output busy,
    output full,
    output acc
  );
  modport control
  (
    output en,
    output start,
    output accumulator_augment_mode,
    output shift_direction_select,
    input  busy,
    input  full,
    input  acc
  );
endinterface

// file: core/crc_feed.sv
// Feed stage: captures flash words or software words for the CRC engine.
`timescale 1ns/1ns
module crc_feed
  import crc_scan_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clear,
  input  wire logic        scan_access,
  input  wire logic        sw_push,
  input  wire logic [15:0] sw_word,
  input  wire logic [15:0] flash_rdata,
  output      logic        idle,
  crc_if.feeder            f
);

  typedef struct packed {
    logic        pend;
    logic        valid;
    logic [15:0] word;
  } feed_state_t;

  feed_state_t s;
  feed_state_t next_s;

  // Flash data arrive the cycle after the read strobe, so one pending flag.
  always_comb
  begin
    next_s = s;
    if (s.valid && f.ready)
      next_s.valid = 1'b0;
    next_s.pend = scan_access;
    if (s.pend)
    begin
      next_s.word  = flash_rdata;
      next_s.valid = 1'b1;
    end
    else if (sw_push)
    begin
      next_s.word  = sw_word;
      next_s.valid = 1'b1;
    end
    if (clear)
    begin
      next_s.pend  = 1'b0;
      next_s.valid = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign idle    = !s.pend && !s.valid;
  assign f.word  = s.word;
  assign f.valid = s.valid;

endmodule

// file: core/crc_shifter.sv
// CRC engine: holding register, bit shifter and accumulator.
`timescale 1ns/1ns
module crc_shifter
  import crc_scan_pkg::*;
#(
  parameter logic [15:0] POLY = DEFAULT_POLY
)
(
  input  wire logic clock,
  input  wire logic sys_rst,
  crc_if.engine     e
);

  typedef enum logic {SH_IDLE, SH_RUN} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic        hold_v;
    logic [15:0] hold;
    logic [15:0] sreg;
    logic [4:0]  cnt;
    logic [15:0] acc;
  } shift_state_t;

  shift_state_t s;
  shift_state_t next_s;
  logic [15:0]  rpoly;
  logic         din;
  logic         fb;

  // Right shifting uses the bit-reversed polynomial.
  always_comb
  begin
    for (int i = 0; i < CRC_W; i++)
      rpoly[i] = POLY[CRC_W-1-i];
  end

  // One data bit enters the accumulator per clock while started.
  always_comb
  begin
    next_s = s;
    din = 1'b0;
    fb  = 1'b0;
    case (s.phase)
      SH_IDLE:
      begin
        if (s.hold_v && e.start)
        begin
          next_s.sreg   = s.hold;
          next_s.cnt    = WORD_BITS;
          next_s.hold_v = 1'b0;
          next_s.phase  = SH_RUN;
        end
      end
      SH_RUN:
      begin
        if (e.start)
        begin
          if (e.shift_direction_select)
          begin
            din = s.sreg[0];
            next_s.sreg = {1'b0, s.sreg[15:1]};
            if (e.accumulator_augment_mode)
            begin
              fb = s.acc[0];
              next_s.acc = {din, s.acc[15:1]} ^ (fb ? rpoly : 16'h0000);
            end
            else
            begin
              fb = s.acc[0] ^ din;
              next_s.acc = {1'b0, s.acc[15:1]} ^ (fb ? rpoly : 16'h0000);
            end
          end
          else
          begin
            din = s.sreg[15];
            next_s.sreg = {s.sreg[14:0], 1'b0};
            if (e.accumulator_augment_mode)
            begin
              fb = s.acc[15];
              next_s.acc = {s.acc[14:0], din} ^ (fb ? POLY : 16'h0000);
            end
            else
            begin
              fb = s.acc[15] ^ din;
              next_s.acc = {s.acc[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
            end
          end
          next_s.cnt = s.cnt - 5'h01;
          if (s.cnt == 5'h01)
            next_s.phase = SH_IDLE;
        end
      end
      default:
        next_s.phase = SH_IDLE;
    endcase
    // A new word is taken only while the holding register is free.
    if (e.valid && !s.hold_v)
    begin
      next_s.hold   = e.word;
      next_s.hold_v = 1'b1;
    end
    // Disabled engine is held in reset.
    if (!e.en)
      next_s = '0;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign e.ready = !s.hold_v;
  assign e.busy  = s.hold_v || (s.phase == SH_RUN);
  assign e.full  = s.hold_v;
  assign e.acc   = s.acc;

endmodule

// file: core/crc_scan_ctrl.sv
// Top of the CRC scanner: registers, scan sequencing and debug interplay.
`timescale 1ns/1ns
module crc_scan_ctrl
  import crc_scan_pkg::*;
#(
  parameter logic [15:0] POLY = DEFAULT_POLY
)
(
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output      logic [7:0]  reg_rdata,
  input  wire logic        dbg_halt_req,
  input  wire logic        dbg_pc_break,
  input  wire logic        dbg_data_break,
  input  wire logic        dbg_step_done,
  input  wire logic        dbg_sw_break,
  input  wire logic        dbg_resume,
  output      logic        dbg_enter,
  output      logic        scan_frozen,
  input  wire logic        cpu_dead_cycle,
  input  wire logic        scan_trigger,
  output      logic        cpu_stall,
  output      logic        flash_rd_en,
  output      logic [15:0] flash_addr,
  input  wire logic [15:0] flash_rdata
);

  typedef struct packed {
    logic        en;
    logic        start;
    logic        accumulator_augment_mode;
    logic        shift_direction_select;
    logic        go;
    logic [1:0]  mode;
    logic [15:0] cur_addr;
    logic [15:0] end_addr;
    logic [7:0]  data_lo;
    logic [7:0]  data_hi;
    logic        lo_w;
    logic        hi_w;
    logic        frozen;
    logic        entry_pend;
    logic        go_deferred;
    logic        pace;
    logic        trig_q;
    logic        trig_seen;
    logic [7:0]  rdata;
  } ctrl_state_t;

  ctrl_state_t s;
  ctrl_state_t next_s;

  logic        feed_idle;
  logic        req_any;
  logic        running;
  logic        want;
  logic        access;
  logic        enter;
  logic        sw_push;
  logic        burst_busy;
  logic        go_write;
  logic [1:0]  wmode;
  logic [7:0]  ctl_view;
  logic [7:0]  scan_view;

  crc_if c ();

  ////////////////////////////////////////////////////////////////////////////
  // Engine and feed stage.

  assign c.en     = s.en;
  assign c.start  = s.start;
  assign c.accumulator_augment_mode   = s.accumulator_augment_mode;
  assign c.shift_direction_select = s.shift_direction_select;

  crc_feed crc_feed_i
  (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .clear       (!s.en),
    .scan_access (access),
    .sw_push     (sw_push),
    .sw_word     ({s.data_hi, s.data_lo}),
    .flash_rdata (flash_rdata),
    .idle        (feed_idle),
    .f           (c)
  );

  crc_shifter #(
    .POLY (POLY)
  ) crc_shifter_i
  (
    .clock   (clock),
    .sys_rst (sys_rst),
    .e       (c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register views built from live state.

  // Full covers both software bytes waiting as well as a held word.
  always_comb
  begin
    ctl_view                 = 8'h00;
    ctl_view[CTL_EN_BIT]     = s.en;
    ctl_view[CTL_START_BIT]  = s.start;
    ctl_view[CTL_BUSY_BIT]   = c.busy || !feed_idle;
    ctl_view[CTL_ACCUMULATOR_AUGMENT_MODE_BIT]   = s.accumulator_augment_mode;
    ctl_view[CTL_SHIFT_DIRECTION_SELECT_BIT] = s.shift_direction_select;
    ctl_view[CTL_FULL_BIT]   = c.full || (s.lo_w && s.hi_w);
    scan_view                = 8'h00;
    scan_view[SCAN_GO_BIT]   = s.go;
    scan_view[SCAN_FROZE_BIT] = s.frozen;
    scan_view[SCAN_MODE_LSB +: 2] = s.mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scan and debug decision for the current cycle.

  // A debug event is seen only once per stay in user mode.
  assign req_any = !s.frozen && (dbg_halt_req || dbg_pc_break
                   || dbg_data_break || dbg_step_done || dbg_sw_break);
  assign running = s.go && !s.frozen;
  assign burst_busy = running && (s.mode == MODE_BURST);
  assign wmode = reg_wdata[SCAN_MODE_LSB +: 2];
  assign go_write = reg_we && (reg_addr == OFS_SCAN_CTL)
                    && reg_wdata[SCAN_GO_BIT] && !s.go && !burst_busy;

  // Whether the scanner could use this cycle for a flash read.
  always_comb
  begin
    want = running && s.en && s.start && feed_idle && !c.full;
    case (s.mode)
      MODE_CONCURRENT: want = want && !s.pace;
      MODE_TRIGGERED:  want = want && !s.pace && s.trig_seen;
      MODE_BURST:      want = want;
      MODE_PEEK:       want = want && cpu_dead_cycle;
      default:         want = 1'b0;
    endcase
  end

  // Entry is either taken now, or owed one cycle after a finishing access.
  always_comb
  begin
    access  = 1'b0;
    enter   = 1'b0;
    if (s.frozen)
    begin
      access = 1'b0;
    end
    else if (s.entry_pend)
    begin
      enter = 1'b1;
    end
    else if (req_any && go_write && (wmode == MODE_BURST))
    begin
      enter = 1'b1;
    end
    else if (req_any)
    begin
      case (s.mode)
        MODE_PEEK:
          enter = 1'b1;
        MODE_BURST:
        begin
          // The access under way completes before the burst is suspended.
          if (want)
            access = 1'b1;
          else
            enter = 1'b1;
        end
        default:
        begin
          if (dbg_data_break)
            enter = 1'b1;
          else if (dbg_halt_req)
            enter = 1'b1;
          else if (want)
            access = 1'b1;
          else
            enter = 1'b1;
        end
      endcase
    end
    else
    begin
      access = want;
    end
  end

  // Software words go to the engine only when the scanner leaves it free.
  assign sw_push = s.lo_w && s.hi_w && feed_idle && !access;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    next_s = s;
    next_s.rdata  = 8'h00;
    next_s.trig_q = scan_trigger;
    next_s.pace   = access && (s.mode != MODE_BURST);
    if (s.entry_pend && !s.frozen)
      next_s.entry_pend = 1'b0;
    if (access && req_any)
      next_s.entry_pend = 1'b1;
    if (enter)
      next_s.frozen = 1'b1;
    // Resume restores user mode; a go write caught by debug takes effect now.
    if (s.frozen && dbg_resume)
    begin
      next_s.frozen = 1'b0;
      if (s.go_deferred)
      begin
        next_s.go          = 1'b1;
        next_s.go_deferred = 1'b0;
      end
    end
    if (running && scan_trigger && !s.trig_q)
      next_s.trig_seen = 1'b1;
    // Each access reads the current address, then advances or ends the scan.
    if (access)
    begin
      if (s.cur_addr == s.end_addr)
      begin
        next_s.go        = 1'b0;
        next_s.trig_seen = 1'b0;
      end
      else
      begin
        next_s.cur_addr = s.cur_addr + 16'h0001;
      end
    end
    if (sw_push)
    begin
      next_s.lo_w = 1'b0;
      next_s.hi_w = 1'b0;
    end
    // Register writes. The CPU is stalled in a burst, so scan writes are ignored.
    if (reg_we)
    begin
      case (reg_addr)
        OFS_CRC_CTL:
        begin
          next_s.en     = reg_wdata[CTL_EN_BIT];
          next_s.start  = reg_wdata[CTL_START_BIT];
          next_s.accumulator_augment_mode   = reg_wdata[CTL_ACCUMULATOR_AUGMENT_MODE_BIT];
          next_s.shift_direction_select = reg_wdata[CTL_SHIFT_DIRECTION_SELECT_BIT];
        end
        OFS_SCAN_CTL:
        begin
          if (!burst_busy)
          begin
            next_s.mode = wmode;
            if (go_write && enter && (wmode == MODE_BURST))
              next_s.go_deferred = 1'b1;
            else
              next_s.go = reg_wdata[SCAN_GO_BIT];
            if (!reg_wdata[SCAN_GO_BIT])
              next_s.trig_seen = 1'b0;
          end
        end
        OFS_ADDR_LO:
          if (!burst_busy)
            next_s.cur_addr[7:0] = reg_wdata;
        OFS_ADDR_HI:
          if (!burst_busy)
            next_s.cur_addr[15:8] = reg_wdata;
        OFS_END_LO:
          if (!burst_busy)
            next_s.end_addr[7:0] = reg_wdata;
        OFS_END_HI:
          if (!burst_busy)
            next_s.end_addr[15:8] = reg_wdata;
        OFS_DATA_LO:
        begin
          next_s.data_lo = reg_wdata;
          next_s.lo_w    = 1'b1;
        end
        OFS_DATA_HI:
        begin
          next_s.data_hi = reg_wdata;
          next_s.hi_w    = 1'b1;
        end
        default:
          next_s.rdata = 8'h00;
      endcase
    end
    // Disabling resets the scanner's internal pacing, not its registers.
    if (!next_s.en)
    begin
      next_s.pace      = 1'b0;
      next_s.trig_seen = 1'b0;
      next_s.lo_w      = 1'b0;
      next_s.hi_w      = 1'b0;
    end
    // Reads answer one cycle later from live state, frozen or not.
    if (reg_re)
    begin
      case (reg_addr)
        OFS_CRC_CTL:  next_s.rdata = ctl_view;
        OFS_SCAN_CTL: next_s.rdata = scan_view;
        OFS_ADDR_LO:  next_s.rdata = s.cur_addr[7:0];
        OFS_ADDR_HI:  next_s.rdata = s.cur_addr[15:8];
        OFS_END_LO:   next_s.rdata = s.end_addr[7:0];
        OFS_END_HI:   next_s.rdata = s.end_addr[15:8];
        OFS_DATA_LO:  next_s.rdata = s.data_lo;
        OFS_DATA_HI:  next_s.rdata = s.data_hi;
        OFS_ACC_LO:   next_s.rdata = c.acc[7:0];
        OFS_ACC_HI:   next_s.rdata = c.acc[15:8];
        default:      next_s.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s          <= '0;
      s.mode     <= SCAN_MODE_RESET;
      s.cur_addr <= ADDR_RESET;
      s.end_addr <= ADDR_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Concurrent and triggered accesses steal one CPU cycle each.
  assign cpu_stall   = (access && (s.mode != MODE_PEEK))
                       || burst_busy;
  assign dbg_enter   = enter;
  assign scan_frozen = s.frozen;
  assign flash_rd_en = access;
  assign flash_addr  = s.cur_addr;
  assign reg_rdata   = s.rdata;

endmodule

// file: test/crc_scan_ctrl_checker.sv
// Port assertions for the CRC scanner control block.
`timescale 1ns/1ns
module crc_scan_ctrl_checker
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        reg_we,
  input wire logic        reg_re,
  input wire logic [7:0]  reg_rdata,
  input wire logic        dbg_pc_break,
  input wire logic        dbg_data_break,
  input wire logic        dbg_step_done,
  input wire logic        dbg_sw_break,
  input wire logic        dbg_resume,
  input wire logic        dbg_enter,
  input wire logic        scan_frozen,
  input wire logic        cpu_stall,
  input wire logic        flash_rd_en,
  input wire logic [15:0] flash_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Entry leads to a freeze; a break met in a stalled read enters later.
  sequence s_freeze;
    dbg_enter ##1 scan_frozen;
  endsequence
  sequence s_read_break;
    (dbg_pc_break || dbg_step_done || dbg_sw_break) && flash_rd_en &&
      cpu_stall && !scan_frozen;
  endsequence
  chk_enter_freeze: assert property (dbg_enter |-> s_freeze)
    else $error("debug entry not followed by a freeze");
  chk_enter_once: assert property (dbg_enter |-> !scan_frozen)
    else $error("debug entry taken while already frozen");
  chk_frozen_idle: assert property
    (scan_frozen |-> !flash_rd_en)
    else $error("flash read while frozen");
  chk_frozen_addr: assert property
    (scan_frozen && !reg_we |=> $stable(flash_addr))
    else $error("scan address moved while frozen");
  chk_thaw_resume: assert property
    (scan_frozen && dbg_resume |=> !scan_frozen)
    else $error("scanner still frozen after resume");
  chk_stay_frozen: assert property
    (scan_frozen && !dbg_resume |=> scan_frozen)
    else $error("freeze dropped without resume");
  chk_scan_first: assert property (s_read_break |=> dbg_enter)
    else $error("break during scan read not entered one cycle later");
  chk_data_now: assert property
    (dbg_data_break && !scan_frozen |-> dbg_enter && !flash_rd_en)
    else $error("data break did not enter at once ahead of the scan");
  chk_rdata_quiet: assert property
    (!$past(reg_re) |-> reg_rdata == 8'h00)
    else $error("read data outside its answer cycle");
endmodule
bind crc_scan_ctrl crc_scan_ctrl_checker crc_scan_ctrl_checker_i (.clock,
  .sys_rst, .reg_we, .reg_re, .reg_rdata, .dbg_pc_break, .dbg_data_break,
  .dbg_step_done, .dbg_sw_break, .dbg_resume, .dbg_enter, .scan_frozen,
  .cpu_stall, .flash_rd_en, .flash_addr);

// file: test/debug_partner.sv
// Model of the debug controller, CPU pipeline and flash read port.
`timescale 1ns/1ns
module debug_partner
(
  input  wire logic        clock,
  input  wire logic        scan_frozen,
  input  wire logic        flash_rd_en,
  input  wire logic [15:0] flash_addr,
  output      logic [4:0]  dbg_line,
  output      logic        dbg_resume,
  output      logic        cpu_dead_cycle,
  output      logic        scan_trigger,
  output      logic [15:0] flash_rdata
);
  logic [2:0] tick = 3'h0;
  initial
  begin
    dbg_line = 5'h00;
    dbg_resume = 1'b0;
    cpu_dead_cycle = 1'b0;
    scan_trigger = 1'b0;
    flash_rdata = 16'h0000;
  end
  ////////////////////////////////////////
  // Flash answers the cycle after a read, then drifts so stale data never
  // looks valid. Dead cycles and trigger edges come from a free tick.
  always @(posedge clock)
  begin
    tick <= tick + 3'h1;
    cpu_dead_cycle <= (tick == 3'h1);
    scan_trigger <= tick[2];
    if (flash_rd_en === 1'b1)
      flash_rdata <= {~flash_addr[7:0], flash_addr[7:0]};
    else
      flash_rdata <= ~flash_rdata;
  end
  // Lines: 0 halt, 1 code break, 2 data break, 3 step, 4 soft break. A
  // halt is a level held until the freeze; breaks tied to a scan read
  // are raised inside that read cycle.
  task automatic raise(input int k, input bit sync);
    if (sync)
      @(negedge clock iff flash_rd_en === 1'b1);
    else
      @(posedge clock);
    dbg_line[k] <= 1'b1;
    if (k == 0)
      wait (scan_frozen === 1'b1);
    else if (sync)
      @(negedge clock);
    else
      @(posedge clock);
    dbg_line[k] <= 1'b0;
  endtask
  // Resume is only ever sent while the scanner is frozen.
  task automatic resume();
    @(posedge clock);
    dbg_resume <= 1'b1;
    @(posedge clock);
    dbg_resume <= 1'b0;
  endtask
endmodule

// file: test/crc_scan_ctrl_tb.sv
// Self-checking bench for the CRC scanner control block.
`timescale 1ns/1ns
module crc_scan_ctrl_tb;
  import crc_scan_pkg::*;
  logic        clock, sys_rst, reg_we, reg_re, dbg_resume, dbg_enter;
  logic        scan_frozen, cpu_dead_cycle, scan_trigger, cpu_stall;
  logic        flash_rd_en;
  logic [4:0]  dbg_line;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic [15:0] flash_addr, flash_rdata, exp_addr;
  logic [1:0]  mode_now;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          reads_cnt = 0;
  int          cyc = 0;
  int          k;
  crc_scan_ctrl crc_scan_ctrl_i (.clock, .sys_rst, .reg_addr, .reg_wdata,
    .reg_we, .reg_re, .reg_rdata, .dbg_halt_req(dbg_line[0]),
    .dbg_pc_break(dbg_line[1]), .dbg_data_break(dbg_line[2]),
    .dbg_step_done(dbg_line[3]), .dbg_sw_break(dbg_line[4]), .dbg_resume,
    .dbg_enter, .scan_frozen, .cpu_dead_cycle, .scan_trigger, .cpu_stall,
    .flash_rd_en, .flash_addr, .flash_rdata);
  debug_partner partner_i (.clock, .scan_frozen, .flash_rd_en, .flash_addr,
    .dbg_line, .dbg_resume, .cpu_dead_cycle, .scan_trigger, .flash_rdata);
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Register port cycles: one-cycle strobes, read data in the next cycle.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_re <= 1'b0;
    @(negedge clock);
    v = reg_rdata;
  endtask
  // Reads are counted mid-cycle, where the strobe has settled; each must
  // land on the next address, which also proves a resume picks up in place.
  always @(negedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      tally_and_finish();
    end
    if (!sys_rst && flash_rd_en === 1'b1)
    begin
      check(flash_addr, exp_addr);
      check(cpu_stall, mode_now != MODE_PEEK);
      if (mode_now == MODE_PEEK)
        check(cpu_dead_cycle, 1'b1);
      exp_addr = exp_addr + 16'h0001;
      reads_cnt++;
    end
  end
  // A 16-word scan hit by one debug event, either on the go write or
  // mid-scan. It must freeze, show its live state, stand still, and
  // finish exactly the remaining words after resume.
  task automatic scan(input logic [1:0] m, input int k, input bit at_go);
    int n;
    int i;
    wr(OFS_ADDR_LO, 8'h00);
    wr(OFS_ADDR_HI, 8'h00);
    wr(OFS_SCAN_CTL, {6'h00, m});
    mode_now = m;
    exp_addr = 16'h0000;
    reads_cnt = 0;
    fork
      wr(OFS_SCAN_CTL, {1'b1, 5'h00, m});
      if (at_go)
        partner_i.raise(k, 1'b0);
    join
    if (!at_go)
    begin
      if (m == MODE_BURST)
        wr(OFS_SCAN_CTL, {6'h00, m});
      wait (reads_cnt >= 3);
      partner_i.raise(k, (k == 1 || k > 2) && m != MODE_PEEK);
    end
    for (i = 0; i < 50 && scan_frozen !== 1'b1; i++)
      @(posedge clock);
    check(scan_frozen, 1'b1);
    if (at_go)
      check(reads_cnt, 0);
    rd(OFS_SCAN_CTL, d);
    check(d, {~at_go, 1'b1, 4'h0, m});
    rd(OFS_ADDR_LO, d);
    check(d, exp_addr[7:0]);
    n = reads_cnt;
    repeat (8) @(posedge clock);
    check(reads_cnt, n);
    partner_i.resume();
    d = 8'h80;
    for (i = 0; i < 400 && d[7] !== 1'b0; i++)
      rd(OFS_SCAN_CTL, d);
    check(reads_cnt, 16);
    check(d, {6'h00, m});
  endtask
  // Main sequence: reset values, register access, then debug scans.
  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    exp_addr = 16'h0000;
    mode_now = 2'h0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    rd(4'hF, d);
    check(d, 8'h00);
    rd(OFS_CRC_CTL, d);
    check(d, CRC_CTL_RESET);
    rd(OFS_SCAN_CTL, d);
    check(d, {6'h00, SCAN_MODE_RESET});
    for (k = 0; k < 4; k++)
    begin
      wr(OFS_SCAN_CTL, {6'h00, k[1:0]});
      rd(OFS_SCAN_CTL, d);
      check(d, {6'h00, k[1:0]});
    end
    // Enabled but not started: the word parks, busy and full stay up.
    wr(OFS_CRC_CTL, 8'h80);
    wr(OFS_DATA_LO, 8'h34);
    wr(OFS_DATA_HI, 8'h12);
    repeat (4) @(posedge clock);
    rd(OFS_CRC_CTL, d);
    check(d, 8'hA1);
    wr(OFS_CRC_CTL, 8'hFF);
    rd(OFS_CRC_CTL, d);
    check(d[5], 1'b1);
    repeat (40) @(posedge clock);
    rd(OFS_CRC_CTL, d);
    check(d, 8'hD2);
    // The first augmented word lands unchanged in a cleared accumulator.
    rd(OFS_ACC_LO, d);
    check(d, 8'h34);
    rd(OFS_ACC_HI, d);
    check(d, 8'h12);
    wr(OFS_END_LO, 8'h0F);
    wr(OFS_END_HI, 8'h00);
    for (k = 0; k < 5; k++)
    begin
      scan(MODE_CONCURRENT, k, 1'b0);
      scan(MODE_TRIGGERED, k, 1'b0);
    end
    scan(MODE_PEEK, 0, 1'b0);
    scan(MODE_PEEK, 1, 1'b0);
    for (k = 0; k < 5; k++)
      if (k != 2)
        scan(MODE_BURST, k, 1'b1);
    scan(MODE_BURST, 0, 1'b0);
    tally_and_finish();
  end
endmodule
